/* hdl/flash_id_consts.svh */
// named opcodes, timings, stream positions and identifier values
`ifndef FLASH_ID_CONSTS_SVH
`define FLASH_ID_CONSTS_SVH

// opcodes
`define OP_SUSPEND      8'h75
`define OP_RESUME       8'h7A
`define OP_SLEEP        8'hB9
`define OP_WAKE_ID      8'hAB
`define OP_MFR_DEV_ID   8'h90
`define OP_MFR_DEV_ID2  8'h92
`define OP_MFR_DEV_ID4  8'h94
`define OP_UNIQUE_ID    8'h4B

// link framing, in serial clocks
`define OPCODE_CLKS     6'h08
`define CYC_MAX         6'h3F
`define ADDR_CLKS_X1    6'h18
`define ADDR_CLKS_X2    6'h0C
`define ADDR_CLKS_X4    6'h06
`define START_WAKE_ID   6'h20
`define START_MFR_X1    6'h20
`define START_MFR_X2    6'h18
`define START_MFR_X4    6'h14
`define START_UNIQUE    6'h28

// output lane enables and address input lanes
`define LANES_NONE      4'h0
`define LANES_X1        4'h2
`define LANES_X2        4'h3
`define LANES_X4        4'hF
`define IN_LANES_X1     4'h1

// timing, the clock period and times in ns
`define CLK_PERIOD_NS   4
`define RESUME_BUSY_NS  200
`define SLEEP_ENTRY_NS  3000
`define WAKE_NS         3000
`define WAKE_ID_NS      1800
// longest times round down, least times round up
`define RESUME_BUSY_CYC (`RESUME_BUSY_NS / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_CYC (`SLEEP_ENTRY_NS / `CLK_PERIOD_NS)
`define WAKE_CYC        ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_ID_CYC     ((`WAKE_ID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_ZERO      12'h000

// identifier values, arbitrary
`define MFR_ID_VAL      8'h5A
`define DEV_ID_VAL      8'h12
`define UNIQUE_ID_VAL   64'h0123_4567_89AB_CDEF

`endif

/* hdl/flash_id_pkg.sv */
// types and decode functions shared by the command interpreter files
`include "flash_id_consts.svh"
package flash_id_pkg;

    typedef enum logic [1:0] {pwr_awake, pwr_entering, pwr_asleep, pwr_waking} pwr_state_t;

    // first serial clock count at which the answer is driven
    function automatic logic [5:0] data_start(input logic [7:0] op);
        unique case (op)
            `OP_WAKE_ID: data_start = `START_WAKE_ID;
            `OP_MFR_DEV_ID: data_start = `START_MFR_X1;
            `OP_MFR_DEV_ID2: data_start = `START_MFR_X2;
            `OP_MFR_DEV_ID4: data_start = `START_MFR_X4;
            `OP_UNIQUE_ID: data_start = `START_UNIQUE;
            default: data_start = `CYC_MAX;
        endcase
    endfunction : data_start

    // clocks spent on the address field
    function automatic logic [5:0] addr_clks(input logic [7:0] op);
        unique case (op)
            `OP_MFR_DEV_ID: addr_clks = `ADDR_CLKS_X1;
            `OP_MFR_DEV_ID2: addr_clks = `ADDR_CLKS_X2;
            `OP_MFR_DEV_ID4: addr_clks = `ADDR_CLKS_X4;
            default: addr_clks = 6'h00;
        endcase
    endfunction : addr_clks

    // lanes that carry address bits in
    function automatic logic [3:0] in_lanes(input logic [7:0] op);
        unique case (op)
            `OP_MFR_DEV_ID2: in_lanes = `LANES_X2;
            `OP_MFR_DEV_ID4: in_lanes = `LANES_X4;
            default: in_lanes = `IN_LANES_X1;
        endcase
    endfunction : in_lanes

endpackage : flash_id_pkg

/* hdl/id_shifter.sv */
// falling-edge serializer for the identifier answers
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"
module id_shifter (
    // link clock and frame
    input wire logic sclk_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    // stream control
    input wire logic active_i,
    input wire logic [7:0] opcode_i,
    input wire logic [5:0] index_i,
    // pin drive
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o
);
    import flash_id_pkg::*;

    wire [15:0] pair = {`MFR_ID_VAL, `DEV_ID_VAL};
    wire [7:0] dev_id = `DEV_ID_VAL;
    wire [63:0] uid = `UNIQUE_ID_VAL;
    wire [7:0] dev_sh = dev_id << index_i[2:0];
    wire [15:0] pair_sh1 = pair << index_i[3:0];
    wire [15:0] pair_sh2 = pair << {index_i[2:0], 1'b0};
    wire [15:0] pair_sh4 = pair << {index_i[1:0], 2'b00};
    wire [63:0] uid_sh = uid << index_i;

    logic [3:0] io_next;
    logic [3:0] oe_next;

    // index wraps at 64, a multiple of every stream length, so repeats stay aligned
    always_comb begin
        io_next = 4'h0;
        oe_next = `LANES_NONE;
        if (active_i) begin
            unique case (opcode_i)
                `OP_WAKE_ID: begin
                    io_next = {2'b00, dev_sh[7], 1'b0};
                    oe_next = `LANES_X1;
                end
                `OP_MFR_DEV_ID: begin
                    io_next = {2'b00, pair_sh1[15], 1'b0};
                    oe_next = `LANES_X1;
                end
                `OP_MFR_DEV_ID2: begin
                    io_next = {2'b00, pair_sh2[15:14]};
                    oe_next = `LANES_X2;
                end
                `OP_MFR_DEV_ID4: begin
                    io_next = pair_sh4[15:12];
                    oe_next = `LANES_X4;
                end
                `OP_UNIQUE_ID: begin
                    io_next = {2'b00, uid_sh[63], 1'b0};
                    oe_next = `LANES_X1;
                end
                default: begin
                    io_next = 4'h0;
                    oe_next = `LANES_NONE;
                end
            endcase
        end
    end

    // answers change on falling edges; select high releases the pins at once
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_o <= 4'h0;
            io_oe_o <= `LANES_NONE;
        end else if (cs_n_i) begin
            io_o <= 4'h0;
            io_oe_o <= `LANES_NONE;
        end else begin
            io_o <= io_next;
            io_oe_o <= oe_next;
        end
    end

endmodule : id_shifter
`default_nettype wire

/* hdl/flash_resume_powerdown_id_cmds.sv */
// command interpreter for resume, suspend, power-down, wake and identifier reads
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"
module flash_resume_powerdown_id_cmds (
    // system clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // erase and program engine
    input wire logic op_busy_i,
    output logic suspend_o,
    output logic resume_o,
    // status
    output logic busy_o,
    output logic suspend_flag_o,
    output logic sleeping_o,
    output logic ready_o,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o
);
    import flash_id_pkg::*;

    // ---------------- link domain ----------------
    logic in_frame_reg;
    logic [5:0] cyc_cnt_reg;
    logic [5:0] cyc_cnt_next;
    logic [7:0] opcode_reg;
    logic [7:0] opcode_next;
    logic [5:0] dcnt_reg;
    logic [5:0] dcnt_next;
    logic addr_nz_reg;
    logic addr_nz_next;
    logic [2:0] stat_s1_reg;
    logic [2:0] stat_s2_reg;

    // frame marker cleared the moment select goes high
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_frame_reg <= 1'b0;
        end else if (cs_n_i) begin
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= 1'b1;
        end
    end

    wire [5:0] start_w = data_start(opcode_reg);
    wire [5:0] addr_end_w = `OPCODE_CLKS + addr_clks(opcode_reg);
    wire in_addr_w = (cyc_cnt_reg >= `OPCODE_CLKS) && (cyc_cnt_reg < addr_end_w);
    wire addr_bits_w = |(io_i & in_lanes(opcode_reg));
    wire cyc_sat_w = (cyc_cnt_reg == `CYC_MAX);

    // the first edge of a frame restarts every counter, so a cut frame leaves nothing
    assign cyc_cnt_next = !in_frame_reg ? 6'h01 :
                          (cyc_sat_w ? cyc_cnt_reg : cyc_cnt_reg + 6'h01);
    assign opcode_next = !in_frame_reg ? {7'h00, io_i[0]} :
                         ((cyc_cnt_reg < `OPCODE_CLKS) ? {opcode_reg[6:0], io_i[0]} :
                          opcode_reg);
    assign dcnt_next = !in_frame_reg ? 6'h00 :
                       ((cyc_cnt_reg >= start_w) ? dcnt_reg + 6'h01 : dcnt_reg);
    assign addr_nz_next = !in_frame_reg ? 1'b0 :
                          (addr_nz_reg | (in_addr_w & addr_bits_w));

    // counters are not cleared by select so the system side can read them afterwards
    always_ff @(posedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_cnt_reg <= 6'h00;
            opcode_reg <= 8'h00;
            dcnt_reg <= 6'h00;
            addr_nz_reg <= 1'b0;
        end else begin
            cyc_cnt_reg <= cyc_cnt_next;
            opcode_reg <= opcode_next;
            dcnt_reg <= dcnt_next;
            addr_nz_reg <= addr_nz_next;
        end
    end

    // status levels into the link domain: {busy, waking, entering or asleep}
    logic [2:0] stat_lvl;
    always_ff @(posedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_s1_reg <= 3'h0;
            stat_s2_reg <= 3'h0;
        end else begin
            stat_s1_reg <= stat_lvl;
            stat_s2_reg <= stat_s1_reg;
        end
    end

    wire asleep_s = stat_s2_reg[0];
    wire waking_s = stat_s2_reg[1];
    wire busy_s = stat_s2_reg[2];
    wire is_mfr_w = (opcode_reg == `OP_MFR_DEV_ID) || (opcode_reg == `OP_MFR_DEV_ID2) ||
                    (opcode_reg == `OP_MFR_DEV_ID4);
    wire wake_id_ok = (opcode_reg == `OP_WAKE_ID) && !busy_s && !waking_s;
    wire mfr_ok = is_mfr_w && !addr_nz_reg && !asleep_s && !waking_s;
    wire uid_ok = (opcode_reg == `OP_UNIQUE_ID) && !asleep_s && !waking_s;
    wire stream_active = in_frame_reg && (cyc_cnt_reg >= start_w) &&
                         (wake_id_ok || mfr_ok || uid_ok);

    id_shifter u_shifter (
        .sclk_i(sclk_i),
        .arst_n_i(arst_n_i),
        .cs_n_i(cs_n_i),
        .active_i(stream_active),
        .opcode_i(opcode_reg),
        .index_i(dcnt_reg),
        .io_o(io_o),
        .io_oe_o(io_oe_o)
    );

    // ---------------- system domain ----------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic cs_s4_reg;
    logic [7:0] op_seen_reg;
    logic [5:0] cyc_seen_reg;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            cs_s4_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n_i;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            cs_s4_reg <= cs_s3_reg;
        end
    end

    // opcode and count are still while select is high; one capture right after the
    // synchroniser settles keeps a quickly following frame from tearing them
    wire cs_settled = cs_s2_reg && !cs_s3_reg;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_seen_reg <= 8'h00;
            cyc_seen_reg <= 6'h00;
        end else if (cs_settled) begin
            op_seen_reg <= opcode_reg;
            cyc_seen_reg <= cyc_cnt_reg;
        end
    end

    // commands act one cycle after the capture
    wire cs_rise = cs_s3_reg && !cs_s4_reg;
    wire [7:0] op_seen = op_seen_reg;
    wire [5:0] cyc_seen = cyc_seen_reg;
    wire exact8 = (cyc_seen == `OPCODE_CLKS);

    pwr_state_t state_reg;
    pwr_state_t state_next;
    logic [11:0] timer_reg;
    logic [11:0] timer_next;
    logic suspend_flag_reg;
    logic resume_hold_reg;
    logic [11:0] hold_cnt_reg;

    wire entering_w = (state_reg == pwr_entering);
    wire asleep_w = (state_reg == pwr_asleep);
    wire waking_w = (state_reg == pwr_waking);

    // counters stop at zero rather than wrapping to the top
    function automatic logic [11:0] count_down(input logic [11:0] v);
        count_down = (v == `TIMER_ZERO) ? v : v - 12'h001;
    endfunction : count_down

    wire busy_w = op_busy_i || resume_hold_reg;
    wire awake_w = (state_reg == pwr_awake);
    wire suspend_ok = cs_rise && awake_w && exact8 && (op_seen == `OP_SUSPEND) &&
                      !suspend_flag_reg && busy_w;
    wire resume_ok = cs_rise && awake_w && exact8 && (op_seen == `OP_RESUME) &&
                     suspend_flag_reg && !busy_w;
    wire sleep_ok = cs_rise && awake_w && exact8 && (op_seen == `OP_SLEEP);
    wire wake_ok = cs_rise && asleep_w && (op_seen == `OP_WAKE_ID) &&
                   (cyc_seen >= `OPCODE_CLKS) && !busy_w;
    wire timer_done = (timer_reg == `TIMER_ZERO);

    always_comb begin
        state_next = state_reg;
        timer_next = count_down(timer_reg);
        unique case (state_reg)
            pwr_awake: begin
                if (sleep_ok) begin
                    state_next = pwr_entering;
                    timer_next = 12'(`SLEEP_ENTRY_CYC);
                end
            end
            pwr_entering: begin
                if (timer_done) begin
                    state_next = pwr_asleep;
                end
            end
            pwr_asleep: begin
                if (wake_ok && exact8) begin
                    state_next = pwr_waking;
                    timer_next = 12'(`WAKE_CYC);
                end else if (wake_ok) begin
                    state_next = pwr_waking;
                    timer_next = 12'(`WAKE_ID_CYC);
                end
            end
            pwr_waking: begin
                if (timer_done) begin
                    state_next = pwr_awake;
                end
            end
        endcase
    end

    // reset is the power-on event: awake, nothing suspended
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= pwr_awake;
            timer_reg <= `TIMER_ZERO;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // suspend flag; lost at reset so a later resume finds it clear
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            suspend_flag_reg <= 1'b0;
        end else if (suspend_ok) begin
            suspend_flag_reg <= 1'b1;
        end else if (resume_ok) begin
            suspend_flag_reg <= 1'b0;
        end
    end

    // busy is held high from the accepted resume until the engine takes over or the hold count runs out
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_cnt_reg <= `TIMER_ZERO;
        end else if (resume_ok) begin
            hold_cnt_reg <= 12'(`RESUME_BUSY_CYC);
        end else if (op_busy_i) begin
            hold_cnt_reg <= `TIMER_ZERO;
        end else begin
            hold_cnt_reg <= count_down(hold_cnt_reg);
        end
    end

    // the hold never outlasts its count, so a stalled engine cannot pin busy high
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resume_hold_reg <= 1'b0;
        end else if (resume_ok) begin
            resume_hold_reg <= 1'b1;
        end else if (op_busy_i || hold_cnt_reg == `TIMER_ZERO) begin
            resume_hold_reg <= 1'b0;
        end
    end

    // engine requests are one-cycle pulses; the guard after resume is the host's to keep
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            suspend_o <= 1'b0;
            resume_o <= 1'b0;
        end else begin
            suspend_o <= suspend_ok;
            resume_o <= resume_ok;
        end
    end

    assign stat_lvl = {busy_w, waking_w, entering_w || asleep_w};
    assign busy_o = busy_w;
    assign suspend_flag_o = suspend_flag_reg;
    assign sleeping_o = asleep_w;
    assign ready_o = awake_w;

endmodule : flash_resume_powerdown_id_cmds
`default_nettype wire

/* dv/flash_cmds_assertions.sv */
// timing and ordering checks at the command interpreter's ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"
module flash_cmds_checker (
    // system side
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic op_busy_i,
    input wire logic suspend_o,
    input wire logic resume_o,
    input wire logic busy_o,
    input wire logic suspend_flag_o,
    input wire logic sleeping_o,
    input wire logic ready_o,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe_o
);
    // small slack covers the select synchroniser
    localparam int RES_CYC = `RESUME_BUSY_CYC;
    localparam int ENTRY_MAX = `SLEEP_ENTRY_CYC + 10;
    localparam int WAKE_MAX = `WAKE_CYC + 10;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    a_resume_needs_flag: assert property (resume_o |->
        ($past(suspend_flag_o) || $past(suspend_flag_o, 2)) && !$past(op_busy_i))
        else $error("resume without suspend flag or while busy");
    a_resume_clears_flag: assert property ($fell(suspend_flag_o) |->
        ##[0:1] (resume_o || $past(resume_o))) else $error("flag cleared without resume");
    a_resume_busy_time: assert property (resume_o |-> ##[0:RES_CYC] busy_o)
        else $error("busy late after resume");
    a_suspend_needs_busy: assert property (suspend_o |->
        !$past(suspend_flag_o) && $past(busy_o)) else $error("suspend taken wrongly");
    a_suspend_sets_flag: assert property (suspend_o |-> suspend_flag_o)
        else $error("suspend flag not set");
    a_pulse_single: assert property ((suspend_o || resume_o) |=>
        !(suspend_o || resume_o)) else $error("engine pulse too long");
    a_sleep_entry_time: assert property ($fell(ready_o) |->
        ##[1:ENTRY_MAX] sleeping_o) else $error("sleep entry too slow");
    a_wake_delay_kept: assert property ($fell(sleeping_o) |->
        !ready_o [*8] ##[1:WAKE_MAX] ready_o) else $error("wake delay wrong");
    a_asleep_inert: assert property (sleeping_o |->
        !ready_o && !suspend_o && !resume_o) else $error("asleep but acting");
    a_asleep_id_only: assert property ((sleeping_o && io_oe_o != `LANES_NONE) |->
        io_oe_o == `LANES_X1) else $error("asleep read answered");
    a_select_quiet: assert property (cs_n_i |-> io_oe_o == `LANES_NONE)
        else $error("driving with select high");
    a_lane_widths: assert property (io_oe_o inside {`LANES_NONE, `LANES_X1,
        `LANES_X2, `LANES_X4}) else $error("odd lane enable");
endmodule : flash_cmds_checker
bind flash_resume_powerdown_id_cmds flash_cmds_checker flash_cmds_checker_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .op_busy_i(op_busy_i), .suspend_o(suspend_o),
    .resume_o(resume_o), .busy_o(busy_o), .suspend_flag_o(suspend_flag_o),
    .sleeping_o(sleeping_o), .ready_o(ready_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o));
`default_nettype wire

/* dv/host_link_model.sv */
// host serial controller: frames opcodes, addresses and reads on the link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // link clock and select
    output logic sclk_o,
    output logic cs_n_o,
    // data lanes
    output logic [3:0] io_i_o,
    input wire logic [3:0] io_o_i,
    input wire logic [3:0] io_oe_i
);
    logic [3:0] drv_val;
    logic [3:0] drv_oe;
    logic [3:0] noise;
    // undriven lanes flip on every rising edge so a stale value never looks valid
    assign io_i_o = (io_oe_i & io_o_i) | (~io_oe_i & drv_oe & drv_val)
        | (~io_oe_i & ~drv_oe & noise);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        drv_val = 4'h0;
        drv_oe = 4'h0;
        noise = 4'h5;
    end
    // lanes change after the falling edge, the device takes them on the rising one
    task automatic clk_edge(input logic [3:0] oe, input logic [3:0] v);
        drv_oe = oe;
        drv_val = v;
        #40;
        sclk_o = 1'b1;
        noise = ~noise;
        #40;
        sclk_o = 1'b0;
    endtask : clk_edge
    task automatic frame(input logic [7:0] op, input int ln, input logic [23:0] a,
        input int ex, input int rd);
        logic [3:0] m;
        int i;
        m = (ln == 4) ? 4'hF : (ln == 2) ? 4'h3 : 4'h1;
        cs_n_o = 1'b0;
        for (i = 7; i >= 0; i--) clk_edge(4'h1, {3'b000, op[i]});
        for (i = 24 - ln; ln > 0 && i >= 0; i -= ln) clk_edge(m, 4'((a >> i) & m));
        // mode bits all ones, a legal Fxh
        for (i = 0; i < ex; i++) clk_edge(m, 4'hF);
        for (i = 0; i < rd; i++) clk_edge(4'h0, 4'h0);
        #40;
        cs_n_o = 1'b1;
        drv_oe = 4'h0;
    endtask : frame
endmodule : host_link_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"
module tb;
    typedef struct packed {logic [3:0] oe; logic [3:0] val;} sym_t;
    logic clock_i, arst_n_i, op_busy_i;
    wire logic suspend_o, resume_o, busy_o, suspend_flag_o, sleeping_o, ready_o, sclk, cs_n;
    wire logic [3:0] io_in, io_out, io_oe;
    int miscompares = 0, total_checks = 0, seen = 0, sus_n = 0, res_n = 0;
    sym_t exp_q[$];
    flash_resume_powerdown_id_cmds flash_resume_powerdown_id_cmds_inst (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .op_busy_i(op_busy_i), .suspend_o(suspend_o), .resume_o(resume_o),
        .busy_o(busy_o), .suspend_flag_o(suspend_flag_o), .sleeping_o(sleeping_o),
        .ready_o(ready_o), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_in), .io_o(io_out),
        .io_oe_o(io_oe));
    host_link_model host_link_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .io_i_o(io_in),
        .io_o_i(io_out), .io_oe_i(io_oe));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD at %0t: %s", $time, what);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    function automatic sym_t mk(input logic [63:0] s, input int len, input int w, input int k);
        sym_t r;
        int b;
        r.oe = (w == 4) ? `LANES_X4 : (w == 2) ? `LANES_X2 : `LANES_X1;
        r.val = 4'h0;
        for (b = 0; b < w; b++) r.val[(w == 1) ? 1 : w - 1 - b] = s[len - 1 - ((k * w + b) % len)];
        return r;
    endfunction : mk
    // answer bits sampled where the host takes them, on the rising link edge
    always @(posedge sclk) begin
        if (io_oe !== `LANES_NONE) begin
            seen++;
            if (exp_q.size() == 0) check(1'b0, "unexpected answer");
            else check({io_oe, io_out & io_oe} === exp_q.pop_front(), "answer symbol");
        end
    end
    always @(posedge clock_i) begin
        if (suspend_o === 1'b1) sus_n++;
        if (resume_o === 1'b1) res_n++;
    end
    task automatic id_read(input logic [7:0] op, input int ln, input int ex, input int rd,
        input logic [63:0] s, input int len, input int w);
        int k;
        for (k = 0; k < rd; k++) exp_q.push_back(mk(s, len, w, k));
        host_link_model_inst.frame(op, ln, 24'h00_0000, ex, rd);
        cyc(8);
        check(exp_q.size() == 0, "stream ended early");
    endtask : id_read
    task automatic quiet(input logic [7:0] op, input int ln, input logic [23:0] a, input int ex);
        int s0;
        s0 = seen;
        host_link_model_inst.frame(op, ln, a, ex, 16);
        cyc(8);
        check(seen == s0, "refused command answered");
    endtask : quiet
    task automatic cmd(input logic [7:0] op, input int ex);
        host_link_model_inst.frame(op, 0, 24'h00_0000, ex, 0);
        cyc(10);
    endtask : cmd
    // whole run is well under 100 us; still waiting at 240 us means a hang
    initial begin
        #240000;
        miscompares++;
        $display("BAD at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        logic [7:0] ops[5] = '{`OP_WAKE_ID, `OP_MFR_DEV_ID, `OP_MFR_DEV_ID2, `OP_MFR_DEV_ID4,
            `OP_UNIQUE_ID};
        int lns[5] = '{0, 1, 2, 4, 0};
        int exs[5] = '{24, 0, 4, 6, 32};
        int ws[5] = '{1, 1, 2, 4, 1};
        int lens[5] = '{8, 16, 16, 16, 64};
        logic [63:0] ss[5] = '{{56'h0, `DEV_ID_VAL}, {48'h0, `MFR_ID_VAL, `DEV_ID_VAL},
            {48'h0, `MFR_ID_VAL, `DEV_ID_VAL}, {48'h0, `MFR_ID_VAL, `DEV_ID_VAL}, `UNIQUE_ID_VAL};
        int t;
        op_busy_i = 1'b0;
        arst_n_i = 1'b0;
        t = $urandom(18);
        cyc(16);
        arst_n_i = 1'b1;
        cyc(4);
        check(ready_o === 1'b1 && sleeping_o === 1'b0, "not awake after reset");
        for (t = 0; t < 5; t++) begin
            id_read(ops[t], lns[t], exs[t], 8 + $urandom % 40, ss[t], lens[t], ws[t]);
        end
        quiet(`OP_MFR_DEV_ID, 1, 24'($urandom) | 24'h01_0000, 0);
        $display("end of identifier reads");
        op_busy_i = 1'b1;
        quiet(`OP_WAKE_ID, 0, 24'h00_0000, 24);
        cmd(`OP_SUSPEND, 0);
        check(suspend_flag_o === 1'b1 && sus_n == 1, "suspend not taken");
        op_busy_i = 1'b0;
        cmd(`OP_RESUME, 1);
        check(suspend_flag_o === 1'b1 && res_n == 0, "late select resumed");
        cmd(`OP_RESUME, 0);
        check(suspend_flag_o === 1'b0 && res_n == 1 && busy_o === 1'b1, "no resume");
        op_busy_i = 1'b1;
        cmd(`OP_RESUME, 0);
        check(res_n == 1, "resume while busy");
        cyc(60);
        cmd(`OP_SUSPEND, 0);
        op_busy_i = 1'b0;
        arst_n_i = 1'b0;
        cyc(4);
        arst_n_i = 1'b1;
        cyc(4);
        cmd(`OP_RESUME, 0);
        check(sus_n == 2 && res_n == 1 && suspend_flag_o === 1'b0, "resume after power loss");
        $display("end of suspend and resume");
        cmd(`OP_SLEEP, 1);
        cyc(800);
        check(sleeping_o === 1'b0 && ready_o === 1'b1, "late select slept");
        cmd(`OP_SLEEP, 0);
        check(ready_o === 1'b0, "ready while entering sleep");
        cyc(760);
        check(sleeping_o === 1'b1, "not asleep");
        quiet(`OP_MFR_DEV_ID, 1, 24'h00_0000, 0);
        op_busy_i = 1'b1;
        cmd(`OP_SUSPEND, 0);
        op_busy_i = 1'b0;
        check(sus_n == 2 && sleeping_o === 1'b1, "asleep took suspend");
        cmd(`OP_WAKE_ID, 0);
        cyc(100);
        check(ready_o === 1'b0, "awake too early");
        cyc(700);
        check(ready_o === 1'b1 && sleeping_o === 1'b0, "did not wake");
        cmd(`OP_SLEEP, 0);
        cyc(760);
        id_read(`OP_WAKE_ID, 0, 24, 16, ss[0], 8, 1);
        cyc(100);
        check(ready_o === 1'b0, "id wake too early");
        cyc(400);
        check(ready_o === 1'b1, "id wake too slow");
        $display("end of power-down");
        complete_run();
    end
endmodule : tb
`default_nettype wire
